//--- inc/stmr_pkg.sv
package stmr_pkg;
  // Byte locations, one AXI word each
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h00;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h04;
  localparam logic [7:0] ADDR_CMP_A_LOW = 8'h08;
  localparam logic [7:0] ADDR_CMP_A_HIGH = 8'h0c;
  localparam logic [7:0] ADDR_CMP_B_LOW = 8'h10;
  localparam logic [7:0] ADDR_CMP_B_HIGH = 8'h14;
  localparam logic [7:0] ADDR_CAPTURE_LOW = 8'h18;
  localparam logic [7:0] ADDR_CAPTURE_HIGH = 8'h1c;
  localparam logic [7:0] ADDR_CONTROL_A = 8'h20;
  localparam logic [7:0] ADDR_CONTROL_B = 8'h24;
  localparam logic [7:0] ADDR_CONTROL_C = 8'h28;
  localparam logic [7:0] ADDR_FLAG = 8'h2c;
  localparam logic [7:0] ADDR_MASK = 8'h30;
  localparam logic [7:0] ADDR_POWER = 8'h34;
  // Flag and mask bit positions
  localparam int FLAG_OVERFLOW = 0;
  localparam int FLAG_CMP_A = 1;
  localparam int FLAG_CMP_B = 2;
  localparam int FLAG_CAPTURE = 5;
  localparam logic [7:0] FLAG_USED = 8'h27;
  // Control field positions
  localparam int CTLA_WGM_LSB = 0;
  localparam int CTLB_CS_LSB = 0;
  localparam int CTLB_WGM_LSB = 3;
  localparam int CTLB_EDGE = 6;
  localparam int CTLB_NOISE = 7;
  localparam int CTLC_COMPARATOR = 0;
  localparam int POWER_REDUCE = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] POWER_RESET = 8'h00;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  // Count limits
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam int NOISE_SAMPLES = 4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    CS_STOP = 3'b000, CS_DIV1 = 3'b001, CS_DIV8 = 3'b010,
    CS_DIV64 = 3'b011, CS_DIV256 = 3'b100, CS_DIV1024 = 3'b101,
    CS_EXT_FALL = 3'b110, CS_EXT_RISE = 3'b111
  } stmr_clock_sel_type;

  typedef struct packed {
    logic [3:0] wgm;
    stmr_clock_sel_type clk_sel;
    logic edge_rise;
    logic noise_en;
    logic use_comparator;
  } stmr_ctrl_type;
endpackage

//--- rtl/stmr_top.sv
// Notes on behaviour
// [R1] One 8-bit high-byte latch per timer for all 16-bit accesses except compare reads.
// [R2] Count, compare and capture share that latch; accesses overwrite it.
// [R3] Low-byte access starts the 16-bit transfer; high-byte touches latch only.
// [R4] Low-byte write loads latch plus new low byte in one cycle.
// [R5] Low-byte read copies register high byte into latch same cycle.
// [R6] Compare reads return both bytes directly, latch untouched.
// [R7] Software writes high byte before low byte.
// [R8] Software reads low byte before high byte.
// [R9] Main code blocks interrupts around its two-byte access.
// [R10] Count zero is BOTTOM.
// [R11] Count all-ones is MAX.
// [R12] TOP is a fixed value, compare A or capture, by mode.
// [R13] Counter advances on prescaler tick or selected external pin edge.
// [R14] No clock source selected: counter holds its value.
// [R15] Buffered compare values compared with count continuously.
// [R16] Compare match sets its compare flag.
// [R17] Compare A as PWM TOP drives no output; TOP double buffered.
// [R18] Pin or comparator edge, optionally filtered, captures the count.
// [R19] Overflow, compare and capture flags, each maskable.
// [R20] Three control registers are plain single-byte accesses.
// [R21] Software clears power reduction bit before use.
// [R22] Count high-byte location reaches the latch, not the counter.
// [R23] CPU count write beats clear or count in the same cycle.
// [R24] High-byte writes change only the latch.
module stmr_top (
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic EXTERNAL_COUNT_PIN_I,
  input wire logic CAPTURE_INPUT_PIN_I,
  input wire logic COMPARATOR_I,
  output logic COMPARE_OUTPUT_A_O,
  output logic COMPARE_OUTPUT_B_O,
  output logic [3:0] IRQ_REQ_O
);
  import stmr_pkg::*;

  logic aw_held, w_held;
  logic [7:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_strb;
  logic [7:0] latch_high;
  logic [15:0] count_value, compare_value_a, compare_value_b;
  logic [15:0] buf_a, buf_b, capture_value;
  logic [7:0] timer_control_a, timer_control_b, timer_control_c;
  logic [7:0] timer_flag_register, timer_mask_register, power_control;
  logic count_down;
  logic [9:0] prescale;
  logic ext_s1, ext_s2, ext_prev;
  logic cap_s1, cap_s2, cmp_s1, cmp_s2;
  logic [NOISE_SAMPLES-1:0] cap_hist;
  logic cap_level, cap_prev;
  stmr_ctrl_type ctrl;
  logic wr_go, rd_go, timer_tick, capture_event, at_top, at_bottom;
  logic [15:0] top_value;
  logic [31:0] rd_word;
  logic rd_ok;

  function automatic logic [15:0] top_of(input logic [3:0] wgm,
      input logic [15:0] ocra, input logic [15:0] icr);
    case (wgm)
      4'h1, 4'h5: top_of = TOP_8BIT;
      4'h2, 4'h6: top_of = TOP_9BIT;
      4'h3, 4'h7: top_of = TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf: top_of = ocra;
      4'h8, 4'ha, 4'hc, 4'he: top_of = icr;
      default: top_of = COUNT_MAX;
    endcase
  endfunction

  function automatic logic is_pwm(input logic [3:0] wgm);
    is_pwm = !(wgm == 4'h0 || wgm == 4'h4 || wgm == 4'hc);
  endfunction

  function automatic logic dual_slope(input logic [3:0] wgm);
    dual_slope = (wgm >= 4'h1 && wgm <= 4'h3) ||
                 (wgm >= 4'h8 && wgm <= 4'hb);
  endfunction

  function automatic logic icr_is_top(input logic [3:0] wgm);
    icr_is_top = (wgm == 4'h8 || wgm == 4'ha || wgm == 4'hc ||
                  wgm == 4'he);
  endfunction

  function automatic logic a_is_top(input logic [3:0] wgm);
    a_is_top = (wgm == 4'h4 || wgm == 4'h9 || wgm == 4'hb ||
                wgm == 4'hf);
  endfunction

  assign ctrl.wgm = {timer_control_b[CTLB_WGM_LSB+1:CTLB_WGM_LSB],
                     timer_control_a[CTLA_WGM_LSB+1:CTLA_WGM_LSB]};
  assign ctrl.clk_sel = stmr_clock_sel_type'(
      timer_control_b[CTLB_CS_LSB+2:CTLB_CS_LSB]);
  assign ctrl.edge_rise = timer_control_b[CTLB_EDGE];
  assign ctrl.noise_en = timer_control_b[CTLB_NOISE];
  assign ctrl.use_comparator = timer_control_c[CTLC_COMPARATOR];

  assign wr_go = aw_held && w_held && !S_AXI_BVALID_O;
  assign rd_go = S_AXI_ARVALID_I && S_AXI_ARREADY_O;

  // AXI write channel: address and data taken in either order
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 8'h00;
      wr_byte <= 8'h00;
      wr_strb <= 1'b0;
      S_AXI_AWREADY_O <= 1'b1;
      S_AXI_WREADY_O <= 1'b1;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_held <= 1'b1;
        wr_addr <= {S_AXI_AWADDR_I[7:2], 2'b00};
        S_AXI_AWREADY_O <= 1'b0;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_held <= 1'b1;
        wr_byte <= S_AXI_WDATA_I[7:0];
        wr_strb <= S_AXI_WSTRB_I[0];
        S_AXI_WREADY_O <= 1'b0;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O <= (wr_addr <= ADDR_POWER) ? RESP_OKAY : RESP_SLVERR;
      end
      if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
        S_AXI_AWREADY_O <= 1'b1;
        S_AXI_WREADY_O <= 1'b1;
      end
    end
  end

  // Read decode; high locations of count and capture show the latch
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    case ({S_AXI_ARADDR_I[7:2], 2'b00})
      ADDR_COUNT_LOW: rd_word[7:0] = count_value[7:0];
      // [R22] high via latch
      ADDR_COUNT_HIGH: rd_word[7:0] = latch_high;
      ADDR_CAPTURE_LOW: rd_word[7:0] = capture_value[7:0];
      ADDR_CAPTURE_HIGH: rd_word[7:0] = latch_high;
      // [R6] compare direct read
      ADDR_CMP_A_LOW: rd_word[7:0] = buf_a[7:0];
      ADDR_CMP_A_HIGH: rd_word[7:0] = buf_a[15:8];
      ADDR_CMP_B_LOW: rd_word[7:0] = buf_b[7:0];
      ADDR_CMP_B_HIGH: rd_word[7:0] = buf_b[15:8];
      ADDR_CONTROL_A: rd_word[7:0] = timer_control_a;
      ADDR_CONTROL_B: rd_word[7:0] = timer_control_b;
      ADDR_CONTROL_C: rd_word[7:0] = timer_control_c;
      ADDR_FLAG: rd_word[7:0] = timer_flag_register;
      ADDR_MASK: rd_word[7:0] = timer_mask_register;
      ADDR_POWER: rd_word[7:0] = power_control;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h0000_0000;
      S_AXI_RRESP_O <= RESP_OKAY;
    end else if (rd_go) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O <= rd_word;
      S_AXI_RRESP_O <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_ARREADY_O <= 1'b1;
    end
  end

  // [R1] shared high-byte latch
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      latch_high <= 8'h00;
    end else if (wr_go && wr_strb && (wr_addr == ADDR_COUNT_HIGH ||
        wr_addr == ADDR_CMP_A_HIGH || wr_addr == ADDR_CMP_B_HIGH ||
        wr_addr == ADDR_CAPTURE_HIGH)) begin
      // [R2] any high write overwrites
      latch_high <= wr_byte;
    end else if (rd_go) begin
      // [R5] low read fills latch
      case ({S_AXI_ARADDR_I[7:2], 2'b00})
        ADDR_COUNT_LOW: latch_high <= count_value[15:8];
        ADDR_CAPTURE_LOW: latch_high <= capture_value[15:8];
        default: latch_high <= latch_high;
      endcase
    end
  end

  // [R20] plain byte control registers
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      timer_control_a <= CONTROL_RESET;
      timer_control_b <= CONTROL_RESET;
      timer_control_c <= CONTROL_RESET;
      timer_mask_register <= CONTROL_RESET;
      power_control <= POWER_RESET;
    end else if (wr_go && wr_strb) begin
      case (wr_addr)
        ADDR_CONTROL_A: timer_control_a <= wr_byte;
        ADDR_CONTROL_B: timer_control_b <= wr_byte;
        ADDR_CONTROL_C: timer_control_c <= wr_byte;
        ADDR_MASK: timer_mask_register <= wr_byte & FLAG_USED;
        ADDR_POWER: power_control <= wr_byte;
        default: ;
      endcase
    end
  end

  // Prescaler and external pin; the sync chain feeds only the edge detect
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      prescale <= 10'h000;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      prescale <= prescale + 10'h001;
      ext_s1 <= EXTERNAL_COUNT_PIN_I;
      ext_s2 <= ext_s1;
      ext_prev <= ext_s2;
    end
  end

  // [R13] tick source select
  always_comb begin
    case (ctrl.clk_sel)
      CS_DIV1: timer_tick = 1'b1;
      CS_DIV8: timer_tick = &prescale[2:0];
      CS_DIV64: timer_tick = &prescale[5:0];
      CS_DIV256: timer_tick = &prescale[7:0];
      CS_DIV1024: timer_tick = &prescale;
      CS_EXT_FALL: timer_tick = ext_prev && !ext_s2;
      CS_EXT_RISE: timer_tick = ext_s2 && !ext_prev;
      // [R14] stopped, count holds
      default: timer_tick = 1'b0;
    endcase
    // Power reduction stops counting and capture; the prescaler keeps running
    if (power_control[POWER_REDUCE]) begin
      timer_tick = 1'b0;
    end
  end

  // [R12] TOP by mode
  assign top_value = top_of(ctrl.wgm, compare_value_a, capture_value);
  // [R10] BOTTOM at zero
  assign at_bottom = (count_value == COUNT_BOTTOM);
  assign at_top = (count_value == top_value);

  // Counter with direction for dual-slope modes
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      count_value <= VALUE_RESET;
      count_down <= 1'b0;
    end else if (wr_go && wr_strb && wr_addr == ADDR_COUNT_LOW) begin
      // [R3] low write starts transfer
      // [R23] CPU write wins
      // [R4] latch and low byte together
      count_value <= {latch_high, wr_byte};
    end else if (timer_tick) begin
      if (dual_slope(ctrl.wgm)) begin
        if (at_top) begin
          count_down <= 1'b1;
          count_value <= count_value - 16'h0001;
        end else if (at_bottom && count_down) begin
          count_down <= 1'b0;
          count_value <= count_value + 16'h0001;
        end else if (count_down) begin
          count_value <= count_value - 16'h0001;
        end else begin
          count_value <= count_value + 16'h0001;
        end
      end else begin
        count_down <= 1'b0;
        count_value <= at_top ? COUNT_BOTTOM : count_value + 16'h0001;
      end
    end
  end

  // [R17] double-buffered compare and TOP; PWM loads at TOP or BOTTOM
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      buf_a <= VALUE_RESET;
      buf_b <= VALUE_RESET;
      compare_value_a <= VALUE_RESET;
      compare_value_b <= VALUE_RESET;
    end else begin
      // [R24] only low writes load
      if (wr_go && wr_strb && wr_addr == ADDR_CMP_A_LOW) begin
        buf_a <= {latch_high, wr_byte};
      end
      if (wr_go && wr_strb && wr_addr == ADDR_CMP_B_LOW) begin
        buf_b <= {latch_high, wr_byte};
      end
      if (!is_pwm(ctrl.wgm) || (timer_tick &&
          (dual_slope(ctrl.wgm) ? at_bottom : at_top))) begin
        compare_value_a <= buf_a;
        compare_value_b <= buf_b;
      end
    end
  end

  // Capture path; filter needs equal samples before a level change
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cap_s1 <= 1'b0;
      cap_s2 <= 1'b0;
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      cap_hist <= '0;
      cap_level <= 1'b0;
      cap_prev <= 1'b0;
    end else begin
      cap_s1 <= CAPTURE_INPUT_PIN_I;
      cap_s2 <= cap_s1;
      cmp_s1 <= COMPARATOR_I;
      cmp_s2 <= cmp_s1;
      cap_hist <= {cap_hist[NOISE_SAMPLES-2:0],
                   ctrl.use_comparator ? cmp_s2 : cap_s2};
      if (!ctrl.noise_en) begin
        cap_level <= cap_hist[0];
      end else if (&cap_hist || !(|cap_hist)) begin
        cap_level <= cap_hist[0];
      end
      cap_prev <= cap_level;
    end
  end

  // [R18] edge select, no capture while capture defines TOP
  assign capture_event = !icr_is_top(ctrl.wgm) &&
      !power_control[POWER_REDUCE] &&
      (ctrl.edge_rise ? (cap_level && !cap_prev) : (!cap_level && cap_prev));

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      capture_value <= VALUE_RESET;
    end else if (capture_event) begin
      capture_value <= count_value;
    end else if (wr_go && wr_strb && wr_addr == ADDR_CAPTURE_LOW &&
        icr_is_top(ctrl.wgm)) begin
      capture_value <= {latch_high, wr_byte};
    end
  end

  // [R19] flags: set beats write-one-to-clear
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      timer_flag_register <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (wr_go && wr_strb && wr_addr == ADDR_FLAG && wr_byte[i]) begin
          timer_flag_register[i] <= 1'b0;
        end
      end
      // [R11] overflow at MAX, at TOP in single-slope PWM, at BOTTOM in dual-slope modes
      if (timer_tick && (dual_slope(ctrl.wgm) ? (at_bottom && count_down)
          : (is_pwm(ctrl.wgm) ? at_top : count_value == COUNT_MAX))) begin
        timer_flag_register[FLAG_OVERFLOW] <= 1'b1;
      end
      // [R16] match sets flag
      if (timer_tick && count_value == compare_value_a) begin
        timer_flag_register[FLAG_CMP_A] <= 1'b1;
      end
      if (timer_tick && count_value == compare_value_b) begin
        timer_flag_register[FLAG_CMP_B] <= 1'b1;
      end
      if (capture_event) begin
        timer_flag_register[FLAG_CAPTURE] <= 1'b1;
      end
    end
  end

  // [R15] continuous compare to outputs
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      COMPARE_OUTPUT_A_O <= 1'b0;
      COMPARE_OUTPUT_B_O <= 1'b0;
      IRQ_REQ_O <= 4'h0;
    end else begin
      // [R17] A as PWM TOP drives nothing
      COMPARE_OUTPUT_A_O <= (count_value == compare_value_a) &&
          !(is_pwm(ctrl.wgm) && a_is_top(ctrl.wgm));
      COMPARE_OUTPUT_B_O <= (count_value == compare_value_b);
      IRQ_REQ_O <= {timer_flag_register[FLAG_CAPTURE],
                    timer_flag_register[FLAG_CMP_B],
                    timer_flag_register[FLAG_CMP_A],
                    timer_flag_register[FLAG_OVERFLOW]} &
                   {timer_mask_register[FLAG_CAPTURE],
                    timer_mask_register[FLAG_CMP_B],
                    timer_mask_register[FLAG_CMP_A],
                    timer_mask_register[FLAG_OVERFLOW]};
    end
  end
endmodule

//--- test/stmr_props.sv
module stmr_props
  import stmr_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic [1:0] S_AXI_RRESP_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  sequence wr_both;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
  endsequence
  sequence rd_taken;
    S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  endsequence
  write_answer_a: assert property (wr_both |-> ##[1:2] S_AXI_BVALID_O)
    else $error("write response missing");
  write_block_a: assert property (wr_both |=>
    !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
    else $error("write channel not blocked after transfer");
  bvalid_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=>
    S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
    else $error("write response dropped before accept");
  bvalid_release_a: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I
    |=> !S_AXI_BVALID_O && S_AXI_AWREADY_O)
    else $error("write response not released");
  read_answer_a: assert property (rd_taken |=> S_AXI_RVALID_O)
    else $error("read data late");
  read_block_a: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
    else $error("read address taken while data pending");
  rvalid_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
    S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
    else $error("read data changed before accept");
  rdata_byte_a: assert property (S_AXI_RVALID_O |->
    S_AXI_RDATA_O[31:8] == 24'h0)
    else $error("read data wider than a byte");
  // The two low address bits are ignored, so decode on the word address
  unmapped_read_a: assert property (rd_taken ##0
    ({S_AXI_ARADDR_I[7:2], 2'b00} > ADDR_POWER) |=>
    S_AXI_RRESP_O == RESP_SLVERR)
    else $error("unmapped read not refused");
  mapped_read_a: assert property (rd_taken ##0
    ({S_AXI_ARADDR_I[7:2], 2'b00} <= ADDR_POWER) |=>
    S_AXI_RRESP_O == RESP_OKAY)
    else $error("mapped read refused");
endmodule

bind stmr_top stmr_props u_props (
  .REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I),
  .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
  .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
  .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
  .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
  .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
  .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RRESP_O(S_AXI_RRESP_O),
  .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I)
);

//--- test/stmr_pin_model.sv
module stmr_pin_model (
  input wire logic clk_i,
  output logic count_pin_o,
  output logic capture_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    count_pin_o = 1'h0;
    capture_pin_o = 1'h0;
  end
  // Four cycles per level, so the 2-flop sync never misses an edge
  task automatic pulse_count(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_i);
      count_pin_o <= 1'h1;
      repeat (4) @(posedge clk_i);
      count_pin_o <= 1'h0;
    end
  endtask
  task automatic capture_edge();
    @(posedge clk_i);
    capture_pin_o <= ~capture_pin_o;
  endtask
endmodule

//--- test/test_sixteen_bit_timer_access.sv
module test_sixteen_bit_timer_access
  import stmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, count_pin, cap_pin;
  logic [1:0] bresp, rresp, cmp_out;
  logic [31:0] rdata;
  logic [3:0] irq;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;

  stmr_top u_dut (
    .REF_CLK_I(clk), .RSTN_I(rstn),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .EXTERNAL_COUNT_PIN_I(count_pin),
    .CAPTURE_INPUT_PIN_I(cap_pin), .COMPARATOR_I(1'h0),
    .COMPARE_OUTPUT_A_O(cmp_out[0]), .COMPARE_OUTPUT_B_O(cmp_out[1]),
    .IRQ_REQ_O(irq)
  );
  stmr_pin_model u_pins (
    .clk_i(clk), .count_pin_o(count_pin), .capture_pin_o(cap_pin)
  );

  always #5 clk = ~clk;

  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // An edge passes before each request, so no strobe is set twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    logic done;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      done = bvalid;
    end while (!done);
    bready <= 1'h0;
    r = bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic done;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
      done = rvalid;
    end while (!done);
    rready <= 1'h0;
    d = rdata;
    r = rresp;
  endtask
  task automatic wv(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  task automatic rv(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, {24'h0, e});
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic t_reset();
    rv(ADDR_CONTROL_B, CONTROL_RESET);
    rv(ADDR_POWER, POWER_RESET);
    rv(ADDR_COUNT_LOW, VALUE_RESET[7:0]);
    rv(ADDR_FLAG, 8'h00);
    // Count and both compare values are zero, so both outputs match
    chk({30'h0, cmp_out}, 32'h3);
    $display("reset values done");
  endtask
  // a single master; the test splits pairs on purpose to show the shared latch
  task automatic t_latch();
    wv(ADDR_CMP_A_HIGH, 8'hab);
    wv(ADDR_CMP_A_LOW, 8'hcd);
    rv(ADDR_CMP_A_HIGH, 8'hab);
    wv(ADDR_COUNT_HIGH, 8'h12);
    rv(ADDR_CMP_A_LOW, 8'hcd);
    wv(ADDR_COUNT_LOW, 8'h34);
    rv(ADDR_COUNT_LOW, 8'h34);
    rv(ADDR_COUNT_HIGH, 8'h12);
    wv(ADDR_COUNT_HIGH, 8'h99);
    rv(ADDR_COUNT_LOW, 8'h34);
    rv(ADDR_COUNT_HIGH, 8'h12);
    wv(ADDR_CMP_B_HIGH, 8'h9a);
    rv(ADDR_COUNT_HIGH, 8'h9a);
    wv(ADDR_CMP_B_HIGH, 8'h00);
    wv(ADDR_CMP_B_LOW, 8'h00);
    wv(ADDR_CMP_A_LOW, 8'h01);
    $display("shared latch done");
  endtask
  task automatic t_count();
    wv(ADDR_FLAG, 8'hff);
    wv(ADDR_COUNT_HIGH, 8'hff);
    wv(ADDR_COUNT_LOW, 8'hfe);
    wv(ADDR_CONTROL_B, {5'h00, CS_EXT_RISE});
    u_pins.pulse_count(5);
    repeat (8) @(posedge clk);
    rv(ADDR_COUNT_LOW, 8'h03);
    rv(ADDR_COUNT_HIGH, 8'h00);
    // Wrap through MAX, then compare B at zero and compare A at one
    rv(ADDR_FLAG, 8'h07);
    wv(ADDR_MASK, 8'h07);
    repeat (2) @(posedge clk);
    chk({28'h0, irq}, 32'h7);
    wv(ADDR_FLAG, 8'h01);
    repeat (2) @(posedge clk);
    chk({28'h0, irq}, 32'h6);
    wv(ADDR_CONTROL_B, 8'h00);
    u_pins.pulse_count(3);
    repeat (8) @(posedge clk);
    rv(ADDR_COUNT_LOW, 8'h03);
    $display("counting done");
  endtask
  task automatic t_capture();
    wv(ADDR_FLAG, 8'hff);
    wv(ADDR_COUNT_HIGH, 8'h02);
    wv(ADDR_COUNT_LOW, 8'h03);
    wv(ADDR_CONTROL_B, 8'h40);
    u_pins.capture_edge();
    repeat (12) @(posedge clk);
    rv(ADDR_CAPTURE_LOW, 8'h03);
    rv(ADDR_CAPTURE_HIGH, 8'h02);
    rv(ADDR_FLAG, 8'h20);
    chk({28'h0, irq}, 32'h0);
    $display("capture done");
  endtask
  // Clear on compare A: TOP is one, so three ticks from zero end at one
  task automatic t_top();
    wv(ADDR_COUNT_HIGH, 8'h00);
    wv(ADDR_COUNT_LOW, 8'h00);
    wv(ADDR_CONTROL_B, 8'h0f);
    u_pins.pulse_count(3);
    repeat (8) @(posedge clk);
    wv(ADDR_CONTROL_B, 8'h08);
    rv(ADDR_COUNT_LOW, 8'h01);
    chk({30'h0, cmp_out}, 32'h1);
    // No overflow here: it comes at MAX only in this mode
    rv(ADDR_FLAG, 8'h26);
    $display("top from compare done");
  endtask
  task automatic t_bus();
    logic [31:0] d;
    logic [1:0] r;
    wv(ADDR_CONTROL_A, 8'h03);
    rv(ADDR_CONTROL_A, 8'h03);
    wv(ADDR_CONTROL_C, 8'h01);
    rv(ADDR_CONTROL_C, 8'h01);
    wv(ADDR_CONTROL_C, 8'h00);
    wv(ADDR_CONTROL_A, 8'h00);
    rd(8'h38, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(8'h3c, 8'h55, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    $display("bus access done");
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    t_reset();
    t_latch();
    t_count();
    t_capture();
    t_top();
    t_bus();
    stop_test();
  end
endmodule
